//--- hw/ccf_pkg.sv
// Constants, field layouts and carrier types for the channel configuration
// and fault status register bank.
// Assumes an 8-bit register port and eight converter channels.

package ccf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_CH = 8;
   localparam int unsigned CH_IDX_W = 3;
   localparam int unsigned PERMILLE_W = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADDR_FAULT_CTRL = 8'h04;
   localparam logic [7:0] ADDR_CH_FIRST   = 8'h05;
   localparam logic [7:0] ADDR_CH_LAST    = 8'h0C;
   localparam logic [7:0] ADDR_POS_STATUS = 8'h12;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h21;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h22;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] FAULT_CTRL_RESET  = 8'h00;
   localparam logic [7:0] CH_SETTINGS_RESET = 8'h10;
   localparam logic [7:0] POS_STATUS_RESET  = 8'h00;
   localparam logic [7:0] IRQ_RESET         = 8'h00;
   localparam logic [7:0] UNMAPPED_READ     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned THR_MSB     = 7;
   localparam int unsigned THR_LSB     = 5;
   localparam int unsigned CH_PD_BIT   = 7;
   localparam int unsigned CH_GAIN_MSB = 6;
   localparam int unsigned CH_GAIN_LSB = 4;
   localparam int unsigned CH_RSVD_BIT = 3;
   localparam int unsigned CH_MUX_MSB  = 2;
   localparam int unsigned CH_MUX_LSB  = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Threshold levels in tenths of a percent of full scale
   localparam logic [9:0] HI_950 = 10'h3B6;
   localparam logic [9:0] HI_925 = 10'h39D;
   localparam logic [9:0] HI_900 = 10'h384;
   localparam logic [9:0] HI_875 = 10'h36B;
   localparam logic [9:0] HI_850 = 10'h352;
   localparam logic [9:0] HI_800 = 10'h320;
   localparam logic [9:0] HI_700 = 10'h2BC;
   localparam logic [9:0] HI_NONE = 10'h000;
   localparam logic [9:0] LO_050 = 10'h032;
   localparam logic [9:0] LO_075 = 10'h04B;
   localparam logic [9:0] LO_100 = 10'h064;
   localparam logic [9:0] LO_125 = 10'h07D;
   localparam logic [9:0] LO_150 = 10'h096;
   localparam logic [9:0] LO_200 = 10'h0C8;
   localparam logic [9:0] LO_250 = 10'h0FA;
   localparam logic [9:0] LO_300 = 10'h12C;

   ////////////////////////////////////////////////////////////////////////////
   // Gain and input select codes, and the threshold code with no high side
   localparam logic [2:0] GAIN_X1  = 3'h1;
   localparam logic [2:0] GAIN_X2  = 3'h2;
   localparam logic [2:0] GAIN_X4  = 3'h4;
   localparam logic [2:0] GAIN_X8  = 3'h5;
   localparam logic [2:0] GAIN_X12 = 3'h6;
   localparam logic [2:0] MUX_NORMAL = 3'h0;
   localparam logic [2:0] MUX_SHORTED = 3'h1;
   localparam logic [2:0] MUX_SUPPLY_MEASURE = 3'h3;
   localparam logic [2:0] MUX_TEMPERATURE = 3'h4;
   localparam logic [2:0] MUX_TEST = 3'h5;
   localparam logic [2:0] THR_NO_HIGH = 3'h6;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic       power_down;
      logic [2:0] gain_select;
      logic [2:0] input_select;
   } ccf_channel_settings_type;

   typedef struct packed {
      logic [9:0] high_permille;
      logic       high_valid;
      logic [9:0] low_permille;
   } ccf_threshold_type;

   ////////////////////////////////////////////////////////////////////////////
   // Decoders shared by logic and checks
   function automatic ccf_threshold_type threshold_decode(input logic [2:0] code);
      ccf_threshold_type t;
      t.high_valid = 1'b1;
      case (code)
         3'h0: begin t.high_permille = HI_950; t.low_permille = LO_050; end
         3'h1: begin t.high_permille = HI_925; t.low_permille = LO_075; end
         3'h2: begin t.high_permille = HI_900; t.low_permille = LO_100; end
         3'h3: begin t.high_permille = HI_875; t.low_permille = LO_125; end
         3'h4: begin t.high_permille = HI_850; t.low_permille = LO_150; end
         3'h5: begin t.high_permille = HI_800; t.low_permille = LO_200; end
         3'h6: begin t.high_permille = HI_NONE; t.low_permille = LO_250; t.high_valid = 1'b0; end
         default: begin t.high_permille = HI_700; t.low_permille = LO_300; end
      endcase
      return t;
   endfunction : threshold_decode

   function automatic logic gain_legal(input logic [2:0] code);
      return (code == GAIN_X1) || (code == GAIN_X2) || (code == GAIN_X4) ||
             (code == GAIN_X8) || (code == GAIN_X12);
   endfunction : gain_legal

   function automatic logic mux_legal(input logic [2:0] code);
      return (code == MUX_NORMAL) || (code == MUX_SHORTED) || (code == MUX_SUPPLY_MEASURE) ||
             (code == MUX_TEMPERATURE) || (code == MUX_TEST);
   endfunction : mux_legal

   function automatic ccf_channel_settings_type byte_to_settings(input logic [7:0] b);
      ccf_channel_settings_type s;
      s.power_down   = b[CH_PD_BIT];
      s.gain_select  = b[CH_GAIN_MSB:CH_GAIN_LSB];
      s.input_select = b[CH_MUX_MSB:CH_MUX_LSB];
      return s;
   endfunction : byte_to_settings

   function automatic logic [7:0] settings_to_byte(input ccf_channel_settings_type s);
      return {s.power_down, s.gain_select, 1'b0, s.input_select};
   endfunction : settings_to_byte

endpackage : ccf_pkg

//--- hw/ccf_level_sync.sv
// Two-stage synchroniser for the eight comparator levels.
// Assumes the levels come from the analog comparators, asynchronous to the clock.

`timescale 1ns/1ns
`default_nettype none

module ccf_level_sync (
   // Clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst_n,
   // Asynchronous levels
   input  wire logic [ccf_pkg::NUM_CH-1:0] i_level,
   // Synchronised levels
   output logic      [ccf_pkg::NUM_CH-1:0] o_level
);

   logic [ccf_pkg::NUM_CH-1:0] meta_reg;
   logic [ccf_pkg::NUM_CH-1:0] sync_reg;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         meta_reg <= ccf_pkg::POS_STATUS_RESET;
         sync_reg <= ccf_pkg::POS_STATUS_RESET;
      end else begin
         meta_reg <= i_level;
         sync_reg <= meta_reg;
      end
   end

   assign o_level = sync_reg;

endmodule : ccf_level_sync

`default_nettype wire

//--- hw/ccf_regs.sv
// Channel configuration and fault status register bank, top level.
// Assumes a single-master register port with one-cycle strobes and read data
// returned in the cycle after the read strobe; comparator levels arrive asynchronously.
//
// Summary of operation
// - Bits 7 to 5 of the fault control register hold one read/write threshold code shared by all channels.
// - The high-side threshold decodes as 95, 92.5, 90, 87.5, 85, 80 and 70 percent for codes 0 to 5 and 7.
// - The low-side threshold decodes as 5, 7.5, 10, 12.5, 15, 20, 25 and 30 percent for codes 0 to 7.
// - Reserved fault control bits 4 to 0 and channel bit 3 are written as zero and always read zero.
// - Eight channel setting registers of equal layout sit at 05h to 0Ch and reset to 10h.
// - Channel bit 7 powers that channel down when set and is clear after reset.
// - Channel bits 6 to 4 select gain 1, 2, 4, 8 or 12, and codes 000, 011 and 111 are not to be used.
// - Channel bits 2 to 0 select normal, shorted, supply, temperature or test input; 010, 110, 111 forbidden.
// - The read-only positive-input status register at 12h resets to 00h with bit k-1 for channel k.
// - A status bit reads one while that channel's positive input exceeds the selected threshold.

`timescale 1ns/1ns
`default_nettype none

module ccf_regs (
   // Clock and reset
   input  wire logic                                    i_clk_sys,
   input  wire logic                                    i_rst_n,
   // Register port
   input  wire logic [ccf_pkg::ADDR_W-1:0]              i_addr,
   input  wire logic [ccf_pkg::DATA_W-1:0]              i_wr_data,
   input  wire logic                                    i_wr_en,
   input  wire logic                                    i_rd_en,
   output logic      [ccf_pkg::DATA_W-1:0]              o_rd_data,
   // Comparator levels, one per channel positive input
   input  wire logic [ccf_pkg::NUM_CH-1:0]              i_comparator_over,
   // Settings to the analog front end
   output ccf_pkg::ccf_channel_settings_type [ccf_pkg::NUM_CH-1:0] o_channel_settings,
   output logic      [ccf_pkg::NUM_CH-1:0]              o_channel_code_illegal,
   output ccf_pkg::ccf_threshold_type                   o_threshold,
   // Status and interrupt
   output logic      [ccf_pkg::NUM_CH-1:0]              o_positive_input_fault_status,
   output logic                                         o_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic                               wr_fault_ctrl;
   logic                               wr_channel;
   logic                               wr_irq_clear;
   logic                               wr_irq_enable;
   logic [ccf_pkg::CH_IDX_W-1:0]       ch_index;
   logic [ccf_pkg::ADDR_W-1:0]         ch_offset;

   assign ch_offset = i_addr - ccf_pkg::ADDR_CH_FIRST;
   assign ch_index  = ch_offset[ccf_pkg::CH_IDX_W-1:0];

   always_comb begin
      wr_fault_ctrl = 1'b0;
      wr_channel    = 1'b0;
      wr_irq_clear  = 1'b0;
      wr_irq_enable = 1'b0;
      if (i_wr_en && i_addr == ccf_pkg::ADDR_FAULT_CTRL) begin
         wr_fault_ctrl = 1'b1;
      end else if (i_wr_en && i_addr >= ccf_pkg::ADDR_CH_FIRST
                   && i_addr <= ccf_pkg::ADDR_CH_LAST) begin
         wr_channel = 1'b1;
      end else if (i_wr_en && i_addr == ccf_pkg::ADDR_IRQ_CLEAR) begin
         wr_irq_clear = 1'b1;
      end else if (i_wr_en && i_addr == ccf_pkg::ADDR_IRQ_ENABLE) begin
         wr_irq_enable = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault threshold control

   logic [2:0]                 thr_code_reg;
   logic [2:0]                 thr_code_next;
   ccf_pkg::ccf_threshold_type threshold_reg;

   assign thr_code_next = wr_fault_ctrl ? i_wr_data[ccf_pkg::THR_MSB:ccf_pkg::THR_LSB]
                                        : thr_code_reg;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         thr_code_reg  <= ccf_pkg::FAULT_CTRL_RESET[ccf_pkg::THR_MSB:ccf_pkg::THR_LSB];
         threshold_reg <= ccf_pkg::threshold_decode(
                             ccf_pkg::FAULT_CTRL_RESET[ccf_pkg::THR_MSB:ccf_pkg::THR_LSB]);
      end else begin
         thr_code_reg  <= thr_code_next;
         threshold_reg <= ccf_pkg::threshold_decode(thr_code_next);
      end
   end

   assign o_threshold = threshold_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Channel settings

   ccf_pkg::ccf_channel_settings_type [ccf_pkg::NUM_CH-1:0] ch_reg;
   ccf_pkg::ccf_channel_settings_type [ccf_pkg::NUM_CH-1:0] ch_next;
   logic [ccf_pkg::NUM_CH-1:0]                              illegal_reg;

   always_comb begin
      ch_next = ch_reg;
      if (wr_channel) begin
         ch_next[ch_index] = ccf_pkg::byte_to_settings(i_wr_data);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         for (int i = 0; i < ccf_pkg::NUM_CH; i++) begin
            ch_reg[i] <= ccf_pkg::byte_to_settings(ccf_pkg::CH_SETTINGS_RESET);
         end
      end else begin
         ch_reg <= ch_next;
      end
   end

   // Flags a channel programmed with a gain or input code that must not be used
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         illegal_reg <= '0;
      end else begin
         for (int i = 0; i < ccf_pkg::NUM_CH; i++) begin
            illegal_reg[i] <= !ccf_pkg::gain_legal(ch_next[i].gain_select)
                              || !ccf_pkg::mux_legal(ch_next[i].input_select);
         end
      end
   end

   assign o_channel_settings     = ch_reg;
   assign o_channel_code_illegal = illegal_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Positive-input fault status

   logic [ccf_pkg::NUM_CH-1:0] pos_status;

   // Second synchroniser stage is the status itself; nothing latches it
   ccf_level_sync u_level_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_level   (i_comparator_over),
      .o_level   (pos_status)
   );

   assign o_positive_input_fault_status = pos_status;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky fault onset per channel

   logic [ccf_pkg::NUM_CH-1:0] pos_prev_reg;
   logic [ccf_pkg::NUM_CH-1:0] irq_status_reg;
   logic [ccf_pkg::NUM_CH-1:0] irq_status_next;
   logic [ccf_pkg::NUM_CH-1:0] irq_enable_reg;
   logic [ccf_pkg::NUM_CH-1:0] irq_enable_next;
   logic [ccf_pkg::NUM_CH-1:0] fault_onset;
   logic                       irq_reg;

   assign fault_onset     = pos_status & ~pos_prev_reg;
   assign irq_enable_next = wr_irq_enable ? i_wr_data : irq_enable_reg;

   // A new onset in the clearing cycle keeps its bit set
   assign irq_status_next = (irq_status_reg & ~(wr_irq_clear ? i_wr_data : '0)) | fault_onset;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pos_prev_reg   <= ccf_pkg::POS_STATUS_RESET;
         irq_status_reg <= ccf_pkg::IRQ_RESET;
         irq_enable_reg <= ccf_pkg::IRQ_RESET;
         irq_reg        <= 1'b0;
      end else begin
         pos_prev_reg   <= pos_status;
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
         irq_reg        <= |(irq_status_next & irq_enable_next);
      end
   end

   assign o_irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [ccf_pkg::DATA_W-1:0] rd_data_reg;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rd_data_reg <= ccf_pkg::UNMAPPED_READ;
      end else if (!i_rd_en) begin
         rd_data_reg <= ccf_pkg::UNMAPPED_READ;
      end else if (i_addr == ccf_pkg::ADDR_FAULT_CTRL) begin
         rd_data_reg <= {thr_code_reg, 5'h00};
      end else if (i_addr >= ccf_pkg::ADDR_CH_FIRST && i_addr <= ccf_pkg::ADDR_CH_LAST) begin
         rd_data_reg <= ccf_pkg::settings_to_byte(ch_reg[ch_index]);
      end else if (i_addr == ccf_pkg::ADDR_POS_STATUS) begin
         rd_data_reg <= pos_status;
      end else if (i_addr == ccf_pkg::ADDR_IRQ_STATUS) begin
         rd_data_reg <= irq_status_reg;
      end else if (i_addr == ccf_pkg::ADDR_IRQ_ENABLE) begin
         rd_data_reg <= irq_enable_reg;
      end else begin
         rd_data_reg <= ccf_pkg::UNMAPPED_READ;
      end
   end

   assign o_rd_data = rd_data_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_thr_field_stored;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == ccf_pkg::ADDR_FAULT_CTRL) ##1 (i_rd_en && !i_wr_en
         && i_addr == ccf_pkg::ADDR_FAULT_CTRL)
      |=> (o_rd_data[7:5] == $past(i_wr_data[7:5], 2));
   endproperty
   a_thr_field_stored: assert property (p_thr_field_stored)
      else $error("threshold field not read back as written");

   property p_high_875;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == ccf_pkg::ADDR_FAULT_CTRL && i_wr_data[7:5] == 3'h3)
      |=> (o_threshold.high_permille == 10'h36B && o_threshold.high_valid);
   endproperty
   a_high_875: assert property (p_high_875)
      else $error("code 011 did not give 87.5 percent high threshold");

   property p_low_300;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == ccf_pkg::ADDR_FAULT_CTRL && i_wr_data[7:5] == 3'h7)
      |=> (o_threshold.low_permille == 10'h12C && o_threshold.high_permille == 10'h2BC);
   endproperty
   a_low_300: assert property (p_low_300)
      else $error("code 111 did not give 30 and 70 percent thresholds");

   property p_no_high_110;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == ccf_pkg::ADDR_FAULT_CTRL && i_wr_data[7:5] == 3'h6)
      |=> (!o_threshold.high_valid && o_threshold.low_permille == 10'h0FA);
   endproperty
   a_no_high_110: assert property (p_no_high_110)
      else $error("code 110 handled wrongly");

   property p_reserved_zero;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_rd_en && (i_addr == ccf_pkg::ADDR_FAULT_CTRL
         || (i_addr >= ccf_pkg::ADDR_CH_FIRST && i_addr <= ccf_pkg::ADDR_CH_LAST)))
      |=> (o_rd_data[3] == 1'b0) && ($past(i_addr) != ccf_pkg::ADDR_FAULT_CTRL
         || o_rd_data[4:0] == 5'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit read back nonzero");

   property p_channel_reset;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !$past(i_rst_n) |-> (ccf_pkg::settings_to_byte(o_channel_settings[0]) == 8'h10
         && ccf_pkg::settings_to_byte(o_channel_settings[7]) == 8'h10
         && o_channel_settings[3].power_down == 1'b0);
   endproperty
   a_channel_reset: assert property (p_channel_reset)
      else $error("channel settings not 10h after reset");

   property p_power_down;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == 8'h0C)
      |=> (o_channel_settings[7].power_down == $past(i_wr_data[7]))
          ##1 (o_channel_settings[7].power_down == $past(i_wr_data[7], 2) || $past(i_wr_en));
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("channel 8 power-down bit not taken");

   property p_illegal_gain;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == 8'h05 && (i_wr_data[6:4] == 3'h3 || i_wr_data[6:4] == 3'h0))
      |=> o_channel_code_illegal[0];
   endproperty
   a_illegal_gain: assert property (p_illegal_gain)
      else $error("forbidden gain code not flagged");

   property p_illegal_mux;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == 8'h0A && i_wr_data[2:0] == 3'h2) |=> o_channel_code_illegal[5];
   endproperty
   a_illegal_mux: assert property (p_illegal_mux)
      else $error("forbidden input code not flagged");

   property p_status_read;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_rd_en && i_addr == ccf_pkg::ADDR_POS_STATUS)
      |=> (o_rd_data == $past(o_positive_input_fault_status));
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read did not return channel bits");

   property p_status_tracks;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $past(i_rst_n, 2) |-> (o_positive_input_fault_status == $past(i_comparator_over, 2));
   endproperty
   a_status_tracks: assert property (p_status_tracks)
      else $error("status does not follow comparators two cycles later");

   property p_irq_level;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $past(i_rst_n) |-> (o_irq == |(irq_status_reg & irq_enable_reg));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output disagrees with enabled status");

   property p_threshold_hold;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !wr_fault_ctrl |=> $stable(o_threshold);
   endproperty
   a_threshold_hold: assert property (p_threshold_hold)
      else $error("threshold changed without a control write");

   property p_status_write_ignored;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_addr == ccf_pkg::ADDR_POS_STATUS)
      |-> !(wr_fault_ctrl || wr_channel || wr_irq_clear || wr_irq_enable);
   endproperty
   a_status_write_ignored: assert property (p_status_write_ignored)
      else $error("status write reached a register");

   property p_rd_idle;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_rd_en |=> (o_rd_data == ccf_pkg::UNMAPPED_READ);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data did not return to zero after its cycle");

   // Sticky bit survives until a clear names it
   property p_irq_sticky;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (irq_status_reg[0] && !(wr_irq_clear && i_wr_data[0])) |=> irq_status_reg[0];
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("channel 1 interrupt status lost without a clear");

   // An onset in the clearing cycle keeps its bit
   property p_set_wins;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (wr_irq_clear && i_wr_data[0] && fault_onset[0]) |=> irq_status_reg[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a new onset of channel 1");

   c_fault_irq: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_irq));
   c_channel_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_channel ##1 (i_rd_en && i_addr == ccf_pkg::ADDR_CH_LAST));
   c_set_clear_same: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_irq_clear && |(fault_onset & i_wr_data));
   c_thr_change: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fault_ctrl && i_wr_data[7:5] == 3'h5);

endmodule : ccf_regs

`default_nettype wire

//--- dv/ccf_regs_tb.sv
// Self-checking bench for the channel configuration and fault status bank.
// Assumes ccf_pkg and the ccf_regs sources are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module ccf_regs_tb;
   logic                   i_clk_sys = 1'b0;
   logic                   i_rst_n   = 1'b0;
   logic [7:0]             i_addr    = 8'h00;
   logic [7:0]             i_wr_data = 8'h00;
   logic                   i_wr_en   = 1'b0;
   logic                   i_rd_en   = 1'b0;
   logic [7:0]             i_comparator_over = 8'h00;
   logic [7:0]             o_rd_data;
   ccf_pkg::ccf_channel_settings_type [ccf_pkg::NUM_CH-1:0] o_channel_settings;
   logic [7:0]             o_channel_code_illegal;
   ccf_pkg::ccf_threshold_type o_threshold;
   logic [7:0]             o_positive_input_fault_status;
   logic                   o_irq;
   int                     n_mismatch = 0;
   int                     tests_run  = 0;
   logic [7:0]             exp_q[$];
   logic [7:0]             e;
   logic                   rd_d = 1'b0;
   logic [31:0]            seed = 32'h000027A1;
   logic [9:0]             hi_t[8] = '{10'h3B6, 10'h39D, 10'h384, 10'h36B,
                                       10'h352, 10'h320, 10'h000, 10'h2BC};
   logic [9:0]             lo_t[8] = '{10'h032, 10'h04B, 10'h064, 10'h07D,
                                       10'h096, 10'h0C8, 10'h0FA, 10'h12C};
   logic [7:0]             v;

   ccf_regs ccf_regs_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
      .i_comparator_over(i_comparator_over), .o_channel_settings(o_channel_settings),
      .o_channel_code_illegal(o_channel_code_illegal), .o_threshold(o_threshold),
      .o_positive_input_fault_status(o_positive_input_fault_status), .o_irq(o_irq));

   always #5 i_clk_sys = ~i_clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   // Stimulus helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic bad(input logic [7:0] b);
      return !(b[6:4] inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6}) ||
             !(b[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h5});
   endfunction : bad

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_en   <= 1'b1;
      @(posedge i_clk_sys);
      i_wr_en   <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge i_clk_sys);
      i_addr  <= a;
      i_rd_en <= 1'b1;
      exp_q.push_back(x);
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : settle

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////
   // Read data checker: oldest note against the data of the cycle after the strobe
   always @(posedge i_clk_sys) rd_d <= i_rd_en;
   always @(negedge i_clk_sys) begin
      if (rd_d) begin
         e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
         `CHK("rd_data", e, o_rd_data)
      end
   end

   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rd(8'h04, 8'h00);
      for (int k = 0; k < 8; k++) rd(8'h05 + k[7:0], 8'h10);
      rd(8'h12, 8'h00);
      rd(8'h3F, 8'h00);
      `CHK("settings0", {1'b0, ccf_pkg::GAIN_X1, ccf_pkg::MUX_NORMAL}, o_channel_settings[0])
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h04, {c[2:0], 5'h1F});
         settle(1);
         `CHK("threshold", {hi_t[c], c != 6, lo_t[c]}, o_threshold)
         rd(8'h04, {c[2:0], 5'h00});
      end
      $display("test threshold done");
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            v = r ? seed[7:0] : {k[0], k[2:0], 1'b1, 3'h7 - k[2:0]};
            wr(8'h05 + k[7:0], v);
            settle(1);
            `CHK("settings", {v[7:4], v[2:0]}, o_channel_settings[k])
            `CHK("illegal", bad(v), o_channel_code_illegal[k])
            rd(8'h05 + k[7:0], v & 8'hF7);
         end
      end
      $display("test channels done");
      seed = xs(seed);
      @(posedge i_clk_sys);
      i_comparator_over <= seed[7:0];
      settle(3);
      `CHK("status", seed[7:0], o_positive_input_fault_status)
      wr(8'h12, ~seed[7:0]);
      rd(8'h12, seed[7:0]);
      i_comparator_over <= 8'h00;
      settle(3);
      `CHK("status_low", 8'h00, o_positive_input_fault_status)
      rd(8'h12, 8'h00);
      $display("test status done");
      wr(8'h21, 8'hFF);
      wr(8'h22, 8'h01);
      rd(8'h20, 8'h00);
      rd(8'h22, 8'h01);
      i_comparator_over <= 8'h02;
      settle(5);
      `CHK("irq_masked", 1'b0, o_irq)
      i_comparator_over <= 8'h03;
      settle(5);
      `CHK("irq_set", 1'b1, o_irq)
      i_comparator_over <= 8'h00;
      settle(4);
      `CHK("irq_sticky", 1'b1, o_irq)
      rd(8'h20, 8'h03);
      wr(8'h21, 8'h01);
      settle(2);
      `CHK("irq_clear", 1'b0, o_irq)
      rd(8'h20, 8'h02);
      // Clear of channel 1 lands in the cycle of its new onset: the set must win
      i_comparator_over <= 8'h01;
      @(posedge i_clk_sys);
      wr(8'h21, 8'h01);
      rd(8'h20, 8'h03);
      `CHK("irq_set_wins", 1'b1, o_irq)
      $display("test interrupt done");
      settle(3);
      `CHK("queue_empty", 0, exp_q.size())
      finish_test();
   end
endmodule : ccf_regs_tb
`default_nettype wire
